// >>> pkg/cswf_pkg.sv
// package: constants and carriers for the switch function command handler
package cswf_pkg;
    // argument layout
    localparam int ARG_MODE_BIT = 31;
    localparam int GRP_W        = 4;
    localparam int NUM_GRP      = 6;
    localparam int SEL_W        = GRP_W * NUM_GRP;
    // selector values
    localparam logic [3:0] FN_DEFAULT = 4'h0;
    localparam logic [3:0] FN_KEEP    = 4'hF;
    localparam logic [3:0] SPD_MAX    = 4'h4;
    localparam logic [3:0] DRV_MAX    = 4'h3;
    localparam logic [3:0] PWR_MAX    = 4'h4;
    localparam logic [3:0] PWR_1W80   = 4'h4;
    localparam logic [3:0] PWR_2W16   = 4'h2;
    localparam logic [3:0] PWR_2W88   = 4'h3;
    localparam logic [3:0] CMDX_ECOM  = 4'h1;
    localparam logic [3:0] CMDX_OTP   = 4'h3;
    localparam logic [3:0] CMDX_SEC   = 4'h4;
    localparam logic [3:0] CMDX_EMB   = 4'hC;
    localparam logic [3:0] CMDX_VEND  = 4'hE;
    // card state code for transfer state
    localparam logic [3:0] CST_TRAN   = 4'h4;
    // status block
    localparam int STAT_BITS   = 512;
    localparam int STAT_CUR_HI = 511;
    localparam int STAT_CUR_LO = 496;
    localparam int STAT_SEL_HI = 399;
    localparam int STAT_SEL_LO = 376;
    localparam int SUP_LO      = 400;
    // timing
    localparam int  SW_DONE_CLKS   = 8;
    localparam real RD_TIMEOUT_MS  = 100.0;
    localparam real CLK_MHZ        = 50.0;
    localparam int  RD_TIMEOUT_CYC =
        int'(RD_TIMEOUT_MS * 1000.0 * CLK_MHZ);
    // maximum current in milliamperes, default selection
    localparam logic [15:0] CUR_BASE_MA = 16'h0064;
    localparam logic [15:0] CUR_STEP_MA = 16'h0032;

    typedef struct packed {
        logic             set_mode;
        logic [SEL_W-1:0] sel;
    } cswf_cmd_t;

    typedef struct packed {
        logic [3:0] g6;
        logic [3:0] g5;
        logic [3:0] pwr;
        logic [3:0] drv;
        logic [3:0] cmdx;
        logic [3:0] spd;
    } cswf_fn_t;
endpackage

// >>> rtl/cswf_ser.sv
// block serialiser: start bit, 512 data bits, crc16, end bit on one lane
`timescale 1ns/1ps
module cswf_ser (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    // bus clock falling edge enable
    input  wire logic                         tick_i,
    // request
    input  wire logic                         start_i,
    input  wire logic [cswf_pkg::STAT_BITS-1:0] blk_i,
    // line
    output logic                              dat_o,
    output logic                              dat_oe_o,
    output logic                              busy_o,
    output logic                              end_o
);
    localparam logic [9:0] LAST_DATA = 10'(cswf_pkg::STAT_BITS);
    localparam logic [9:0] LAST_CRC  = 10'(cswf_pkg::STAT_BITS + 16);
    localparam logic [9:0] END_POS   = 10'(cswf_pkg::STAT_BITS + 17);

    logic [cswf_pkg::STAT_BITS-1:0] sh_r;
    logic [15:0]                    crc_r;
    logic [9:0]                     pos_r;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic b);
        logic fb;
        fb = c[15] ^ b;
        crc_step = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    endfunction

    // position 0 start bit, 1..512 data, 513..528 crc, 529 end bit
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_o   <= 1'b0;
            dat_o    <= 1'b1;
            dat_oe_o <= 1'b0;
            end_o    <= 1'b0;
            pos_r    <= 10'h000;
            sh_r     <= '0;
            crc_r    <= 16'h0000;
        end else begin
            end_o <= 1'b0;
            if (start_i && !busy_o) begin
                busy_o <= 1'b1;
                sh_r   <= blk_i;
                crc_r  <= 16'h0000;
                pos_r  <= 10'h000;
            end else if (busy_o && tick_i) begin
                dat_oe_o <= 1'b1;
                pos_r    <= pos_r + 10'h001;
                if (pos_r == 10'h000) begin
                    dat_o <= 1'b0;
                end else if (pos_r <= LAST_DATA) begin
                    dat_o <= sh_r[cswf_pkg::STAT_BITS-1];
                    crc_r <= crc_step(crc_r, sh_r[cswf_pkg::STAT_BITS-1]);
                    sh_r  <= {sh_r[cswf_pkg::STAT_BITS-2:0], 1'b0};
                end else if (pos_r <= LAST_CRC) begin
                    dat_o <= crc_r[15];
                    crc_r <= {crc_r[14:0], 1'b0};
                end else if (pos_r == END_POS) begin
                    dat_o <= 1'b1;
                end else begin
                    // line released one bus clock after end bit
                    dat_oe_o <= 1'b0;
                    busy_o   <= 1'b0;
                    end_o    <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> rtl/cswf_top.sv
// switch function command handler, card side
`timescale 1ns/1ps
module cswf_top (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    // bus clock pin from host
    input  wire logic                    bus_clk_i,
    // decoded command from the command line front end
    input  wire logic                    cmd_valid_i,
    input  wire logic                    cmd_is_switch_i,
    input  wire logic                    cmd_is_reset_i,
    input  wire logic [31:0]             cmd_arg_i,
    input  wire logic [3:0]              card_state_i,
    // static configuration
    input  wire logic                    uhs_mode_i,
    input  wire logic                    embedded_i,
    input  wire logic [3:0]              busy_grp_i,
    // response request to the command line front end
    output logic                         r1_req_o,
    output logic                         illegal_cmd_o,
    output logic                         go_idle_o,
    // data line 0
    output logic                         dat0_o,
    output logic                         dat0_oe_o,
    output logic                         xfer_busy_o,
    // active functions
    output cswf_pkg::cswf_fn_t           fn_o,
    output logic                         ccc_switch_o,
    output logic [15:0]                  power_cap_ma_o
);
    typedef enum logic [1:0] {
        CSWF_IDLE  = 2'b00,
        CSWF_SEND  = 2'b01,
        CSWF_APPLY = 2'b10
    } cswf_state_t;

    cswf_state_t                      st_r;
    cswf_pkg::cswf_fn_t               cur_r;
    cswf_pkg::cswf_fn_t               pend_r;
    logic                             pend_ret_r;
    logic [cswf_pkg::STAT_BITS-1:0]   blk_r;
    logic                             ser_start_r;
    logic                             bclk_s1_r;
    logic                             bclk_s2_r;
    logic                             bclk_s3_r;
    logic                             bclk_fall;
    logic                             ser_dat;
    logic                             ser_oe;
    logic                             ser_end;
    logic                             rst_pend_r;
    logic                             sw_take;
    logic                             busy_nxt;

    // pin is asynchronous: two flops before any use
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bclk_s1_r <= 1'b0;
            bclk_s2_r <= 1'b0;
            bclk_s3_r <= 1'b0;
        end else begin
            bclk_s1_r <= bus_clk_i;
            bclk_s2_r <= bclk_s1_r;
            bclk_s3_r <= bclk_s2_r;
        end
    end
    assign bclk_fall = bclk_s3_r & ~bclk_s2_r;

    // per-group validity; 0xF is always legal
    function automatic logic sel_ok(input int g, input logic [3:0] v,
                                    input logic uhs);
        logic ok;
        ok = 1'b0;
        if (v == cswf_pkg::FN_KEEP || v == cswf_pkg::FN_DEFAULT) begin
            ok = 1'b1;
        end else begin
            case (g)
                0: ok = uhs ? (v <= cswf_pkg::SPD_MAX) : (v == 4'h1);
                1: ok = (v == cswf_pkg::CMDX_ECOM) ||
                        (v == cswf_pkg::CMDX_OTP)  ||
                        (v == cswf_pkg::CMDX_SEC)  ||
                        (v == cswf_pkg::CMDX_EMB)  ||
                        (v == cswf_pkg::CMDX_VEND);
                2: ok = (v <= cswf_pkg::DRV_MAX);
                3: ok = (v <= cswf_pkg::PWR_MAX);
                default: ok = 1'b0; // reserved groups
            endcase
        end
        sel_ok = ok;
    endfunction

    // support bitmap of one group, function 15 always reported
    function automatic logic [15:0] sup_map(input int g, input logic uhs);
        logic [15:0] m;
        m = 16'h8001;
        case (g)
            0: m = uhs ? 16'h801F : 16'h8003;
            1: m = 16'hD01B;
            2: m = 16'h800F;
            3: m = 16'h801F;
            default: m = 16'h8001;
        endcase
        sup_map = m;
    endfunction

    // power cap in milliamps; removable card never above the 1.80W step
    function automatic logic [15:0] pwr_ma(input logic [3:0] p,
                                           input logic emb);
        logic [3:0] e;
        e = p;
        if (!emb && (p == cswf_pkg::PWR_2W16 || p == cswf_pkg::PWR_2W88)) begin
            e = cswf_pkg::PWR_1W80;
        end
        pwr_ma = cswf_pkg::CUR_BASE_MA +
                 16'(e) * cswf_pkg::CUR_STEP_MA;
    endfunction

    // argument decode and status build
    cswf_pkg::cswf_cmd_t cmd;
    cswf_pkg::cswf_fn_t  req;
    cswf_pkg::cswf_fn_t  tgt;
    cswf_pkg::cswf_fn_t  nxt_fn;
    logic [5:0]          bad;
    logic                any_bad;
    logic [cswf_pkg::STAT_BITS-1:0] blk_nxt;

    always_comb begin
        cmd.set_mode = cmd_arg_i[cswf_pkg::ARG_MODE_BIT];
        cmd.sel      = cmd_arg_i[cswf_pkg::SEL_W-1:0];
        req          = cmd.sel;
        for (int g = 0; g < cswf_pkg::NUM_GRP; g++) begin
            bad[g] = ~sel_ok(g, req[g*4 +: 4], uhs_mode_i);
        end
        any_bad = |bad;
        tgt    = cur_r;
        nxt_fn = cur_r;
        for (int g = 0; g < cswf_pkg::NUM_GRP; g++) begin
            if (bad[g]) begin
                tgt[g*4 +: 4] = cswf_pkg::FN_KEEP;
            end else if (req[g*4 +: 4] == cswf_pkg::FN_KEEP ||
                         (cmd.set_mode && any_bad)) begin
                tgt[g*4 +: 4] = cur_r[g*4 +: 4];
            end else if (busy_grp_i[g % 4] && g < 4) begin
                tgt[g*4 +: 4] = cur_r[g*4 +: 4];
            end else begin
                tgt[g*4 +: 4] = req[g*4 +: 4];
            end
            if (!any_bad && cmd.set_mode) begin
                nxt_fn[g*4 +: 4] = tgt[g*4 +: 4];
            end
        end
        blk_nxt = '0;
        // zero current when anything was invalid
        blk_nxt[cswf_pkg::STAT_CUR_HI:cswf_pkg::STAT_CUR_LO] =
            any_bad ? 16'h0000 : pwr_ma(tgt.pwr, embedded_i);
        for (int g = 0; g < cswf_pkg::NUM_GRP; g++) begin
            blk_nxt[cswf_pkg::SUP_LO + g*16 +: 16] = sup_map(g, uhs_mode_i);
        end
        blk_nxt[cswf_pkg::STAT_SEL_HI:cswf_pkg::STAT_SEL_LO] = tgt;
    end

    // command acceptance and transfer sequencing
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r          <= CSWF_IDLE;
            r1_req_o      <= 1'b0;
            illegal_cmd_o <= 1'b0;
            ser_start_r   <= 1'b0;
            blk_r         <= '0;
            pend_r        <= '0;
            pend_ret_r    <= 1'b0;
        end else begin
            r1_req_o      <= 1'b0;
            illegal_cmd_o <= 1'b0;
            ser_start_r   <= 1'b0;
            case (st_r)
                CSWF_IDLE: begin
                    if (cmd_valid_i && cmd_is_switch_i) begin
                        r1_req_o <= 1'b1;
                        if (card_state_i != cswf_pkg::CST_TRAN) begin
                            illegal_cmd_o <= 1'b1;
                        end else begin
                            blk_r       <= blk_nxt;
                            pend_r      <= nxt_fn;
                            // all-default set drops the card to idle
                            pend_ret_r  <= cmd.set_mode && !any_bad &&
                                           (req == '0);
                            ser_start_r <= 1'b1;
                            st_r        <= CSWF_SEND;
                        end
                    end
                end
                CSWF_SEND: begin
                    if (ser_end) begin
                        st_r <= CSWF_APPLY;
                    end
                end
                CSWF_APPLY: begin
                    st_r <= CSWF_IDLE;
                end
                default: st_r <= CSWF_IDLE;
            endcase
            if (cmd_valid_i && cmd_is_reset_i) begin
                st_r <= CSWF_IDLE;
            end
        end
    end

    // reset command: revert two clocks after the command, far inside 8 clocks
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rst_pend_r <= 1'b0;
        end else begin
            rst_pend_r <= cmd_valid_i && cmd_is_reset_i;
        end
    end

    // busy follows the next state, so it never lags a taken command
    assign sw_take  = (st_r == CSWF_IDLE) && cmd_valid_i &&
                      cmd_is_switch_i &&
                      (card_state_i == cswf_pkg::CST_TRAN);
    assign busy_nxt = !(cmd_valid_i && cmd_is_reset_i) &&
                      (sw_take || (st_r == CSWF_SEND));

    // active function register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cur_r     <= '0;
            go_idle_o <= 1'b0;
        end else begin
            go_idle_o <= 1'b0;
            if (rst_pend_r) begin
                cur_r     <= '0;
                go_idle_o <= 1'b1;
            end else if (st_r == CSWF_APPLY) begin
                // applied one cycle after the line is released
                cur_r     <= pend_r;
                go_idle_o <= pend_ret_r;
            end
        end
    end

    // registered outputs
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fn_o           <= '0;
            power_cap_ma_o <= 16'h0000;
            ccc_switch_o   <= 1'b0;
            dat0_o         <= 1'b1;
            dat0_oe_o      <= 1'b0;
            xfer_busy_o    <= 1'b0;
        end else begin
            fn_o           <= cur_r;
            power_cap_ma_o <= pwr_ma(cur_r.pwr, embedded_i);
            ccc_switch_o   <= 1'b1;
            dat0_o         <= ser_dat;
            dat0_oe_o      <= ser_oe;
            xfer_busy_o    <= busy_nxt;
        end
    end

    cswf_ser u_ser (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .tick_i   (bclk_fall),
        .start_i  (ser_start_r),
        .blk_i    (blk_r),
        .dat_o    (ser_dat),
        .dat_oe_o (ser_oe),
        .busy_o   (),
        .end_o    (ser_end)
    );
endmodule

// >>> sim/cswf_sva.sv
// checker: port assertions for the switch function handler
`timescale 1ns/1ps
module cswf_sva (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               reset_i,
    // command side
    input wire logic               cmd_valid_i,
    input wire logic               cmd_is_switch_i,
    input wire logic               cmd_is_reset_i,
    input wire logic [3:0]         card_state_i,
    input wire logic               embedded_i,
    // answers
    input wire logic               r1_req_o,
    input wire logic               illegal_cmd_o,
    input wire logic               go_idle_o,
    input wire logic               dat0_o,
    input wire logic               dat0_oe_o,
    input wire logic               xfer_busy_o,
    input wire cswf_pkg::cswf_fn_t fn_o,
    input wire logic               ccc_switch_o,
    input wire logic [15:0]        power_cap_ma_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic        take;
    logic [3:0]  pwr_eff;
    logic [15:0] cap_exp;
    assign take = cmd_valid_i && cmd_is_switch_i && !xfer_busy_o;
    // removable cards never go past the 1.80W setting
    assign pwr_eff = (!embedded_i && (fn_o.pwr == cswf_pkg::PWR_2W16 ||
        fn_o.pwr == cswf_pkg::PWR_2W88)) ? cswf_pkg::PWR_1W80 : fn_o.pwr;
    assign cap_exp = cswf_pkg::CUR_BASE_MA
        + cswf_pkg::CUR_STEP_MA * {12'h000, pwr_eff};
    a_r1_on_take: assert property (take |=> r1_req_o)
        else $error("switch command got no response");
    a_busy_refused:
        assert property (cmd_valid_i && xfer_busy_o |=> !r1_req_o)
        else $error("command answered during a transfer");
    a_state_check:
        assert property (take |=> illegal_cmd_o ==
            ($past(card_state_i) != cswf_pkg::CST_TRAN))
        else $error("illegal flag does not match card state");
    a_illegal_quiet:
        assert property (illegal_cmd_o |-> r1_req_o ##1 !xfer_busy_o [*8])
        else $error("illegal command started data");
    a_start_low:
        assert property ($rose(dat0_oe_o) |-> !dat0_o && xfer_busy_o)
        else $error("frame does not open with a low start bit");
    a_fn_quiet: assert property ($changed(fn_o) |-> !xfer_busy_o)
        else $error("functions changed during a transfer");
    a_reset_revert:
        assert property (cmd_valid_i && cmd_is_reset_i |->
            ##[1:8] go_idle_o ##1 (fn_o == '0))
        else $error("reset command did not revert functions");
    a_idle_zero: assert property (go_idle_o |=> fn_o == '0)
        else $error("functions not default after going idle");
    a_fn_legal:
        assert property (fn_o.g5 == 4'h0 && fn_o.g6 == 4'h0 &&
            fn_o.spd <= 4'h4 && fn_o.drv <= 4'h3 && fn_o.pwr <= 4'h4)
        else $error("active function out of range");
    a_cap_match:
        assert property (!$past(reset_i) && $stable(fn_o) &&
            $stable(embedded_i) |-> power_cap_ma_o == cap_exp)
        else $error("power cap does not follow power limit");
    a_ccc_on: assert property (!$past(reset_i) |-> ccc_switch_o)
        else $error("switch support bit not advertised");
endmodule

bind cswf_top cswf_sva u_sva (
    .clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
    .cmd_is_switch_i(cmd_is_switch_i), .cmd_is_reset_i(cmd_is_reset_i),
    .card_state_i(card_state_i), .embedded_i(embedded_i),
    .r1_req_o(r1_req_o), .illegal_cmd_o(illegal_cmd_o),
    .go_idle_o(go_idle_o), .dat0_o(dat0_o), .dat0_oe_o(dat0_oe_o),
    .xfer_busy_o(xfer_busy_o), .fn_o(fn_o), .ccc_switch_o(ccc_switch_o),
    .power_cap_ma_o(power_cap_ma_o)
);

// >>> sim/cswf_host.sv
// host model: bus clock source and status block receiver
`timescale 1ns/1ps
module cswf_host (
    // control from the bench
    input  wire logic    run_i,
    // data line as seen on the bus
    input  wire logic    dat0_i,
    // bus clock, still while no frame is wanted
    output logic         bus_clk_o,
    // last received block
    output logic [511:0] blk_o,
    output logic         crc_ok_o,
    output int           frames_o
);
    initial begin
        bus_clk_o = 1'b0;
        crc_ok_o  = 1'b0;
        frames_o  = 0;
        blk_o     = '0;
    end
    // edges sit off the system clock rising edges; the long low phase covers
    // the card's sync and register delay before the host samples
    always begin
        wait (run_i === 1'b1);
        #70 bus_clk_o = 1'b1;
        #75 bus_clk_o = 1'b0;
        #15;
    end
    // samples on the rise, card changes data on the fall
    always begin : rx
        logic [15:0] crc;
        logic [15:0] got;
        int          i;
        @(posedge bus_clk_o);
        if (dat0_i === 1'b0) begin
            crc = 16'h0000;
            for (i = 511; i >= 0; i--) begin
                @(posedge bus_clk_o);
                blk_o[i] = dat0_i;
                crc = {crc[14:0], 1'b0}
                    ^ ((crc[15] ^ dat0_i) ? 16'h1021 : 16'h0000);
            end
            for (i = 15; i >= 0; i--) begin
                @(posedge bus_clk_o);
                got[i] = dat0_i;
            end
            @(posedge bus_clk_o);
            // a bad crc means the outcome is not to be trusted
            crc_ok_o = (got === crc) && (dat0_i === 1'b1);
            frames_o++;
        end
    end
endmodule

// >>> sim/cswf_top_tb_top.sv
// testbench: switch function handler against the host model
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    mismatches++; $display("wrong value at %0t: got %0h expected %0h", \
    $time, got, exp); end end
module cswf_top_tb_top;
    logic               clk_i = 1'b0;
    logic               reset_i = 1'b1;
    logic               cmd_valid = 1'b0, cmd_sw = 1'b0, cmd_rst = 1'b0;
    logic [31:0]        cmd_arg = 32'h0;
    logic [3:0]         card_state = 4'h4, busy = 4'h0;
    logic               uhs = 1'b0, emb = 1'b0, run = 1'b0;
    logic               r1_seen, ill_seen, bus_clk, dat0_line, crc_ok;
    logic               r1, illegal, go_idle, dat0, dat0_oe, xbusy, ccc;
    logic [15:0]        cap;
    logic [511:0]       blk;
    cswf_pkg::cswf_fn_t fn;
    logic [23:0]        fn_m = 24'h0;
    logic [3:0]         codes [5] = '{4'h1, 4'h3, 4'h4, 4'hC, 4'hE};
    int                 frames, k;
    int                 idles = 0, exp_idles = 0;
    int                 mismatches = 0, compares = 0;

    always #10 clk_i = ~clk_i;
    assign dat0_line = dat0_oe ? dat0 : 1'b1; // pulled up when released
    always @(posedge clk_i) begin
        if (go_idle === 1'b1) idles++;
    end

    cswf_top dut (
        .clk_i(clk_i), .reset_i(reset_i), .bus_clk_i(bus_clk),
        .cmd_valid_i(cmd_valid), .cmd_is_switch_i(cmd_sw),
        .cmd_is_reset_i(cmd_rst), .cmd_arg_i(cmd_arg),
        .card_state_i(card_state), .uhs_mode_i(uhs), .embedded_i(emb),
        .busy_grp_i(busy), .r1_req_o(r1), .illegal_cmd_o(illegal),
        .go_idle_o(go_idle), .dat0_o(dat0), .dat0_oe_o(dat0_oe),
        .xfer_busy_o(xbusy), .fn_o(fn), .ccc_switch_o(ccc),
        .power_cap_ma_o(cap)
    );
    cswf_host host (.run_i(run), .dat0_i(dat0_line), .bus_clk_o(bus_clk),
        .blk_o(blk), .crc_ok_o(crc_ok), .frames_o(frames));

    function automatic logic grp_ok(input int g, input logic [3:0] v);
        if (v == 4'hF) return 1'b1;
        case (g)
            0: return v <= 4'h1 || (uhs && v <= 4'h4);
            1: return v inside {4'h0, 4'h1, 4'h3, 4'h4, 4'hC, 4'hE};
            2: return v <= 4'h3;
            3: return v <= 4'h4;
            default: return v == 4'h0;
        endcase
    endfunction

    function automatic logic [15:0] cap_of(input logic [3:0] p);
        if (!emb && (p == 4'h2 || p == 4'h3)) p = 4'h4;
        return cswf_pkg::CUR_BASE_MA + cswf_pkg::CUR_STEP_MA * {12'h000, p};
    endfunction

    task automatic send_cmd(input logic sw, rs, input logic [31:0] a);
        @(posedge clk_i);
        cmd_valid <= 1'b1;
        cmd_sw    <= sw;
        cmd_rst   <= rs;
        cmd_arg   <= a;
        @(posedge clk_i);
        cmd_valid <= 1'b0;
        #1;
        r1_seen  = r1;
        ill_seen = illegal;
    endtask

    task automatic do_sw(input logic m, input logic [23:0] sel,
                         input logic dbl);
        logic [23:0] res;
        logic        ok;
        logic [3:0]  q;
        int          g, n, i;
        ok = 1'b1;
        for (g = 0; g < 6; g++) ok &= grp_ok(g, sel[g*4+:4]);
        for (g = 0; g < 6; g++) begin
            q = sel[g*4+:4];
            if (!grp_ok(g, q)) begin
                res[g*4+:4] = 4'hF;
            end else if (q == 4'hF || (m && !ok) || (g < 4 && busy[g])) begin
                res[g*4+:4] = fn_m[g*4+:4];
            end else begin
                res[g*4+:4] = q;
            end
        end
        n = frames;
        send_cmd(1'b1, 1'b0, {m, 7'h00, sel});
        `CHK(r1_seen, 1'b1)
        `CHK(ill_seen, 1'b0)
        @(posedge clk_i);
        run <= 1'b1;
        if (dbl) begin
            for (i = 0; i < 300 && xbusy !== 1'b1; i++) @(posedge clk_i);
            send_cmd(1'b1, 1'b0, 32'h0);
            `CHK(r1_seen, 1'b0)
        end
        // far below the read timeout, so a hang shows up quickly
        for (i = 0; i < 6000 && frames == n; i++) @(posedge clk_i);
        `CHK(frames != n, 1'b1)
        `CHK(blk[399:376], res)
        `CHK(blk[511:496], ok ? cap_of(res[15:12]) : 16'h0000)
        `CHK(blk[402], uhs)
        `CHK(crc_ok, 1'b1)
        repeat (8) @(posedge bus_clk);
        @(posedge clk_i);
        run <= 1'b0;
        if (m && ok) fn_m = res;
        if (m && sel == 24'h0) exp_idles++;
        `CHK(fn, fn_m)
        `CHK(cap, cap_of(fn_m[15:12]))
        `CHK(idles, exp_idles)
    endtask

    task automatic t_state;
        int n;
        n = frames;
        @(posedge clk_i);
        card_state <= 4'h3;
        send_cmd(1'b1, 1'b0, 32'h80FFFFF1);
        `CHK(ill_seen, 1'b1)
        `CHK(ccc, 1'b1)
        @(posedge clk_i);
        run        <= 1'b1;
        card_state <= 4'h4;
        repeat (300) @(posedge clk_i);
        run <= 1'b0;
        `CHK(frames, n)
        `CHK(fn, fn_m)
    endtask

    task automatic t_reset;
        send_cmd(1'b0, 1'b1, 32'h0);
        repeat (64) @(posedge clk_i);
        fn_m = 24'h0;
        exp_idles++;
        `CHK(fn, fn_m)
        `CHK(idles, exp_idles)
    endtask

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_state;
        do_sw(1'b0, 24'h004311, 1'b0);
        do_sw(1'b0, 24'hFFFFF2, 1'b1);
        busy <= 4'h4;
        @(posedge clk_i);
        do_sw(1'b0, 24'h000100, 1'b0);
        do_sw(1'b1, 24'hFF31F1, 1'b0);
        do_sw(1'b1, 24'h1FFFF0, 1'b0);
        busy <= 4'h0;
        uhs  <= 1'b1;
        emb  <= 1'b1;
        @(posedge clk_i);
        for (k = 0; k < 5; k++) begin
            do_sw(1'b1, {8'h00, k[3:0], k[3:0] & 4'h3, codes[k], k[3:0]},
                  1'b0);
        end
        do_sw(1'b1, 24'h000000, 1'b0);
        do_sw(1'b1, 24'hFF2FF3, 1'b0);
        t_reset;
        close_out;
    end

    // about a dozen frames of some 4300 clocks each fit well inside this
    initial begin
        #1_800_000;
        mismatches++;
        close_out;
    end
endmodule
